// ===== bench/serial_line_partner.sv
// Remote serial partner: async sender and mode 0 shift peripheral
`timescale 1ns/1ps
module serial_line_partner (
	input  wire logic        clk_i,
	input  wire logic        send_i,
	input  wire logic        m0_i,
	input  wire logic        sclk_i,
	input  wire logic [10:0] frame_i,
	input  wire logic [3:0]  nbits_i,
	input  wire logic [7:0]  bit_clks_i,
	output logic             line_o
);
	logic [10:0] sr = '1;
	logic [3:0]  left = '0;
	logic [7:0]  cnt = '0;
	logic        sclk_q = 1'b1;
	initial line_o = 1'b1;
	always @(posedge clk_i) begin
		sclk_q <= sclk_i;
		cnt <= cnt + 8'd1;
		if (send_i) begin
			sr <= frame_i;
			left <= m0_i ? 4'd8 : nbits_i;
			cnt <= 8'd0;
			line_o <= frame_i[0];
		end else if (left != 0 && (m0_i ? sclk_i && !sclk_q : cnt == bit_clks_i - 8'd1)) begin
			sr <= sr >> 1;
			left <= left - 4'd1;
			cnt <= 8'd0;
			// Released mode 0 line inverts, so a stale bit never passes
			line_o <= (left != 1) ? sr[1] : (m0_i ? ~sr[0] : 1'b1);
		end
	end
endmodule

// ===== bench/serial_port_props.sv
// Assertions on the serial port pins and register bus
`timescale 1ns/1ps
module serial_port_props (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic        rx_line_o,
	input  wire logic        rx_line_oe_o,
	input  wire logic        tx_line_o,
	input  wire logic        serial_irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_hole_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'hc |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_irq_flags: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0
		|-> $past(serial_irq_o) == (wb_dat_o[0] | wb_dat_o[1]))
		else $error("irq differs from flags");
	a_clk_low_six: assert property ($fell(tx_line_o) && rx_line_oe_o |-> !tx_line_o [*6] ##1 tx_line_o)
		else $error("shift clock low time wrong");
	a_clk_high_six: assert property ($rose(tx_line_o) && rx_line_oe_o |-> tx_line_o [*6])
		else $error("shift clock high time wrong");
	a_shift_clk_high: assert property (rx_line_oe_o && $changed(rx_line_o) |-> tx_line_o)
		else $error("data moved while clock low");
	a_send_hold: assert property ($rose(rx_line_oe_o) |-> rx_line_oe_o [*8])
		else $error("send dropped early");
	cover property ($rose(rx_line_oe_o));
	cover property ($rose(serial_irq_o));
	cover property (wb_ack_o && wb_adr_i == 4'hc);
endmodule
bind four_mode_serial_port serial_port_props i_serial_port_props (.ref_clk_i, .rst_n_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .rx_line_o, .rx_line_oe_o, .tx_line_o,
	.serial_irq_o);

// ===== bench/tb_four_mode_serial_port.sv
// Self-checking bench for the four mode serial port
`timescale 1ns/1ps
module tb_four_mode_serial_port;
	logic        ref_clk_i, rst_n_i, req, we, send, m0, p_line;
	logic        ovf = 1'b0;
	logic [3:0]  adr, nbits;
	logic [31:0] wdat, wb_dat_o;
	logic        wb_ack_o, rx_line_o, rx_line_oe_o, tx_line_o, serial_irq_o;
	logic [10:0] frame;
	logic [7:0]  bit_clks, m0_byte, q, last_buf;
	logic [9:0]  cap;
	int          fails = 0, num_checks = 0, cycles = 0, ovf_cnt = 0, bc;
	int          hole[3] = '{0, 8, 12};
	logic [7:0]  fl[4] = '{8'h02, 8'h00, 8'h01, 8'h00};
	logic [7:0]  rx_ctl[6] = '{8'h90, 8'hb0, 8'hb0, 8'h80, 8'h50, 8'hd0};
	logic [7:0]  rx_dat[6] = '{8'h5a, 8'h11, 8'h77, 8'h22, 8'hc4, 8'h96};
	logic [5:0]  rx_9th = 6'b011101, rx_keep = 6'b110101;
	wire         rx_line_i = rx_line_oe_o ? rx_line_o : p_line;
	four_mode_serial_port i_four_mode_serial_port (.ref_clk_i, .rst_n_i, .ce_i(1'b1), .wb_cyc_i(req),
		.wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o,
		.wb_ack_o, .timer1_ovf_i(ovf), .rx_line_i, .rx_line_o, .rx_line_oe_o, .tx_line_o, .serial_irq_o);
	serial_line_partner i_serial_line_partner (.clk_i(ref_clk_i), .send_i(send), .m0_i(m0),
		.sclk_i(tx_line_o), .frame_i(frame), .nbits_i(nbits), .bit_clks_i(bit_clks), .line_o(p_line));
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	// Timer overflow every 4 clocks gives 64-clock bits in modes 1 and 3
	always @(posedge ref_clk_i) begin
		ovf_cnt <= (ovf_cnt + 1) % 4;
		ovf <= (ovf_cnt == 3);
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fails = fails + 1;
			stop_test();
		end
	end
	always @(posedge tx_line_o) if (rx_line_oe_o === 1'b1) m0_byte <= {rx_line_o, m0_byte[7:1]};
	task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		req <= 1'b1;
		{we, adr, wdat} <= {w, a, 24'h0, d};
		do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		req <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic wait_flag(input int b);
		do wb(1'b0, 4'h0, 8'h00); while (q[b] !== 1'b1);
	endtask
	task automatic psend(input logic z, input logic [10:0] f, input logic [3:0] n, input logic [7:0] c);
		{m0, frame, nbits, bit_clks} <= {z, f, n, c};
		send <= 1'b1;
		@(posedge ref_clk_i);
		send <= 1'b0;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		rst_n_i = 1'b0;
		req = 1'b0;
		send = 1'b0;
		{we, adr, wdat} = '0;
		{m0, frame, nbits, bit_clks} = '0;
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		wb(1'b1, 4'hc, 8'hff);
		foreach (hole[i]) begin
			wb(1'b0, hole[i][3:0], 8'h00);
			chk("reset read", q, 0);
		end
		chk("idle line", tx_line_o, 1);
		$display("test reset done");
		wb(1'b1, 4'h0, 8'h00);
		wb(1'b1, 4'h4, 8'ha5);
		wait_flag(1);
		chk("m0 tx byte", m0_byte, 8'ha5);
		foreach (fl[i]) begin
			wb(1'b1, 4'h0, fl[i]);
			chk("irq", serial_irq_o, fl[i] != 0);
		end
		psend(1'b1, 11'h03c, 4'd8, 8'd0);
		wb(1'b1, 4'h0, 8'h10);
		wait_flag(0);
		wb(1'b0, 4'h4, 8'h00);
		chk("m0 rx byte", q, 8'h3c);
		$display("test mode 0 done");
		wb(1'b1, 4'h8, 8'h01);
		last_buf = 8'h3c;
		foreach (rx_ctl[i]) begin
			bc = (rx_ctl[i][7:6] == 2'h2) ? 32 : 64;
			wb(1'b1, 4'h0, rx_ctl[i]);
			psend(1'b0, {1'b1, rx_9th[i], rx_dat[i], 1'b0}, (rx_ctl[i][7:6] == 2'h1) ? 4'd10 : 4'd11, bc[7:0]);
			repeat (13 * bc) @(posedge ref_clk_i);
			wb(1'b0, 4'h0, 8'h00);
			chk("rx flag", q[0], rx_keep[i]);
			if (rx_keep[i]) begin
				chk("rx ninth", q[2], rx_9th[i]);
				last_buf = rx_dat[i];
			end
			wb(1'b0, 4'h4, 8'h00);
			chk("rx buffer", q, last_buf);
		end
		wb(1'b1, 4'h0, 8'h90);
		psend(1'b0, 11'h000, 4'd1, 8'd6);
		repeat (13 * 32) @(posedge ref_clk_i);
		wb(1'b0, 4'h0, 8'h00);
		chk("false start", q[0], 0);
		$display("test async receive done");
		for (int m = 1; m < 4; m++) begin
			bc = (m == 2) ? 32 : 64;
			wb(1'b1, 4'h0, {m[1:0], 2'b00, (m == 2), 3'b000});
			fork
				wb(1'b1, 4'h4, 8'hc3 ^ m[7:0]);
				begin
					@(negedge tx_line_o);
					// Start bit may be cut short by machine cycle alignment
					repeat (bc + bc / 4) @(posedge ref_clk_i);
					for (int k = 0; k < 10; k++) begin
						cap[k] = tx_line_o;
						repeat (bc) @(posedge ref_clk_i);
					end
				end
			join
			chk("tx frame", cap, {1'b1, (m != 3), 8'hc3 ^ m[7:0]});
			wb(1'b0, 4'h0, 8'h00);
			chk("tx done flag", q[1], 1);
		end
		$display("test async transmit done");
		stop_test();
	end
endmodule

// ===== rtl/four_mode_serial_port.sv
// Four mode serial port with a classic Wishbone register slave
`timescale 1ns/1ps
`include "serial_port_defs.svh"

module four_mode_serial_port (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        timer1_ovf_i,
	input  wire logic        rx_line_i,
	output logic             rx_line_o,
	output logic             rx_line_oe_o,
	output logic             tx_line_o,
	output logic             serial_irq_o
);
	import serial_port_pkg::*;

	port_state_t r;
	port_state_t next_r;

	logic        tick;
	logic        tx_roll;
	logic        rx_roll;
	logic        state1_phase1;
	logic        state6_phase2;
	logic        rd_req;
	logic        wr_en;
	logic        async_mode;
	logic        nine_bit;
	logic        bit_val;
	reg_sel_t    rd_sel;
	reg_sel_t    wr_sel;

	function automatic reg_sel_t decode_reg(input logic [3:0] adr);
		reg_sel_t s;
		s = REG_NONE;
		if (adr == `SP_ADDR_CTRL) begin
			s = REG_CTRL;
		end else if (adr == `SP_ADDR_BUF) begin
			s = REG_BUF;
		end else if (adr == `SP_ADDR_BAUD) begin
			s = REG_BAUD;
		end
		return s;
	endfunction

	function automatic logic majority(input logic [2:0] v);
		return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// Mode 2 derives its tick from the clock; modes 1 and 3 use timer overflows
	assign tick       = (r.mode == `SP_MODE_9FIX) ?
	                    (r.smod ? r.pre[0] : (r.pre == `SP_M2_SLOW_LAST)) : timer1_ovf_i;
	assign tx_roll    = tick && (r.tx_div == `SP_DIV_LAST);
	assign rx_roll    = tick && (r.rx_div == `SP_DIV_LAST);
	assign state1_phase1       = (r.mc == `SP_STATE1_PHASE1);
	assign state6_phase2       = (r.mc == `SP_STATE6_PHASE2);
	assign rd_req     = wb_cyc_i & wb_stb_i & ~r.ack;
	assign wr_en      = wb_cyc_i & wb_stb_i & wb_we_i & r.ack & wb_sel_i[0];
	assign rd_sel     = decode_reg(wb_adr_i);
	assign wr_sel     = wr_en ? decode_reg(wb_adr_i) : REG_NONE;
	assign async_mode = (r.mode != `SP_MODE_SHIFT);
	assign nine_bit   = r.mode[1];
	assign bit_val    = majority(r.maj);

	always_comb begin
		next_r = r;

		// Twelve clocks per machine cycle, counted STATE1_PHASE1 to STATE6_PHASE2
		next_r.mc  = state6_phase2 ? `SP_STATE1_PHASE1 : r.mc + 4'h1;
		next_r.pre = r.pre + 2'h1;

		// Only the settled pair of synchroniser stages is trusted
		next_r.sy = {r.sy[1:0], rx_line_i};
		if (r.sy[1] == r.sy[2]) begin
			next_r.rx_f = r.sy[2];
		end
		if (tick) begin
			next_r.tx_div  = r.tx_div + 4'h1;
			next_r.rx_div  = r.rx_div + 4'h1;
			next_r.rx_prev = r.rx_f;
		end

		// Bus slave: ack one cycle after the request, write lands on the ack edge
		next_r.ack = rd_req;
		if (rd_req) begin
			unique case (rd_sel)
				REG_CTRL: next_r.rdat = {r.mode, r.sm2, r.ren, r.tb8, r.rb8, r.ti, r.ri};
				REG_BUF:  next_r.rdat = r.serial_buffer_reg;
				REG_BAUD: next_r.rdat = {5'h00, r.rx_st != RX_IDLE, r.tx_st != TX_IDLE, r.smod};
				REG_NONE: next_r.rdat = 8'h00;
			endcase
		end
		if (wr_sel == REG_CTRL) begin
			next_r.mode = wb_dat_i[`SP_F_MODE_HI:`SP_F_MODE_LO];
			next_r.sm2  = wb_dat_i[`SP_F_SM2];
			next_r.ren  = wb_dat_i[`SP_F_REN];
			next_r.tb8  = wb_dat_i[`SP_F_TB8];
			next_r.rb8  = wb_dat_i[`SP_F_RB8];
			next_r.ti   = wb_dat_i[`SP_F_TI];
			next_r.ri   = wb_dat_i[`SP_F_RI];
		end
		if (wr_sel == REG_BAUD) begin
			next_r.smod = wb_dat_i[`SP_F_SMOD];
		end

		// Transmitter; a buffer write while busy is dropped to keep the frame intact
		unique case (r.tx_st)
			TX_IDLE: begin
				if (wr_sel == REG_BUF) begin
					next_r.tsr      = {(nine_bit ? r.tb8 : 1'b1), wb_dat_i[7:0]};
					next_r.tx_first = 1'b1;
					next_r.tx_st    = async_mode ? TX_AS_REQ : TX_M0_PEND;
				end
			end
			TX_M0_PEND: begin
				if (state6_phase2) begin
					next_r.tx_st = TX_M0_ARM;
				end
			end
			TX_M0_ARM: begin
				if (state6_phase2) begin
					next_r.tx_st = TX_M0_SEND;
				end
			end
			TX_M0_SEND: begin
				if (state1_phase1 && r.tsr == `SP_TX_DONE) begin
					next_r.tx_st = TX_IDLE;
					next_r.ti    = 1'b1;
				end else if (state6_phase2) begin
					next_r.tsr = {1'b0, r.tsr[8:1]};
				end
			end
			TX_AS_REQ: begin
				if (tx_roll) begin
					next_r.tx_st = TX_AS_GO;
				end
			end
			TX_AS_GO: begin
				if (state1_phase1) begin
					next_r.tx_st = TX_AS_START;
				end
			end
			TX_AS_START: begin
				if (tx_roll) begin
					next_r.tx_st = TX_AS_DATA;
				end
			end
			TX_AS_DATA: begin
				if (tx_roll) begin
					next_r.tsr      = {r.tx_first & nine_bit, r.tsr[8:1]};
					next_r.tx_first = 1'b0;
					if (!r.tx_first && r.tsr[8:1] == `SP_TX_MARK) begin
						next_r.tx_st = TX_IDLE;
						next_r.ti    = 1'b1;
					end
				end
			end
		endcase

		// Receiver; mode 0 samples the filter bit once at SP_STATE5_PHASE2, without the majority vote
		unique case (r.rx_st)
			RX_IDLE: begin
				if (r.ren && !async_mode) begin
					if (!r.ri && r.tx_st == TX_IDLE) begin
						next_r.rx_st   = RX_M0_ARM;
						next_r.m0_wait = 1'b1;
					end
				end else if (r.ren && tick && r.rx_prev && !r.rx_f) begin
					next_r.rx_div = 4'h0;
					next_r.rsr    = `SP_RX_AS_LOAD;
					next_r.maj    = 3'h0;
					next_r.rx_st  = RX_AS_BITS;
				end
			end
			RX_M0_ARM: begin
				if (state1_phase1) begin
					next_r.m0_wait = 1'b0;
				end
				if (state6_phase2 && !r.m0_wait) begin
					next_r.rsr   = {1'b1, `SP_RX_M0_LOAD};
					next_r.rx_st = RX_M0_SHIFT;
				end
			end
			RX_M0_SHIFT: begin
				if (r.mc == `SP_STATE5_PHASE2) begin
					next_r.samp = r.rx_f;
				end
				if (state1_phase1 && r.m0_wait) begin
					next_r.m0_wait = 1'b0;
					next_r.rx_st   = RX_IDLE;
					next_r.ri      = 1'b1;
				end else if (state6_phase2 && !r.m0_wait) begin
					// Shifting right keeps the first bit in bit 0 of the buffer
					next_r.rsr[7:0] = {r.samp, r.rsr[7:1]};
					if (!r.rsr[0]) begin
						next_r.serial_buffer_reg    = {r.samp, r.rsr[7:1]};
						next_r.m0_wait = 1'b1;
					end
				end
			end
			RX_AS_BITS: begin
				if (!r.ren) begin
					next_r.rx_st = RX_IDLE;
				end else begin
					if (tick && r.rx_div >= `SP_SAMP_FIRST && r.rx_div <= `SP_SAMP_LAST) begin
						next_r.maj = {r.maj[1:0], r.rx_f};
					end
					if (rx_roll) begin
						if (r.rsr == `SP_RX_AS_LOAD && bit_val) begin
							next_r.rx_st = RX_IDLE;
						end else if (!r.rsr[0]) begin
							if (!r.ri && (!r.sm2 || bit_val)) begin
								next_r.serial_buffer_reg = r.rsr[8:1];
								next_r.rb8  = bit_val;
								next_r.ri   = 1'b1;
							end
							next_r.rx_st = nine_bit ? RX_AS_GAP : RX_IDLE;
						end else begin
							next_r.rsr = {bit_val, r.rsr[8:1]};
						end
					end
				end
			end
			RX_AS_GAP: begin
				if (rx_roll) begin
					next_r.rx_st = RX_IDLE;
				end
			end
			default: begin
				next_r.rx_st = RX_IDLE;
			end
		endcase

		// Line drivers follow the next state so pins line up with it
		if (next_r.tx_st == TX_M0_SEND || next_r.rx_st == RX_M0_SHIFT) begin
			next_r.txd = !(next_r.mc >= `SP_STATE3_PHASE1 && next_r.mc < `SP_STATE6_PHASE1);
		end else if (next_r.tx_st == TX_AS_START) begin
			next_r.txd = 1'b0;
		end else if (next_r.tx_st == TX_AS_DATA) begin
			next_r.txd = next_r.tsr[0];
		end else begin
			next_r.txd = `SP_LINE_IDLE;
		end
		next_r.rxo  = next_r.tsr[0];
		next_r.rxoe = (next_r.tx_st == TX_M0_SEND);
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r         <= '0;
			r.txd     <= `SP_LINE_IDLE;
			r.sy      <= 3'h7;
			r.rx_f    <= `SP_LINE_IDLE;
			r.rx_prev <= `SP_LINE_IDLE;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	assign wb_dat_o     = {24'h000000, r.rdat};
	assign wb_ack_o     = r.ack;
	assign rx_line_o    = r.rxo;
	assign rx_line_oe_o = r.rxoe;
	assign tx_line_o    = r.txd;
	assign serial_irq_o = r.ri | r.ti;

endmodule

// ===== rtl/serial_port_defs.svh
// Constants for the four mode serial port
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

`define SP_ADDR_CTRL    4'h0
`define SP_ADDR_BUF     4'h4
`define SP_ADDR_BAUD    4'h8

`define SP_F_RI         0
`define SP_F_TI         1
`define SP_F_RB8        2
`define SP_F_TB8        3
`define SP_F_REN        4
`define SP_F_SM2        5
`define SP_F_MODE_LO    6
`define SP_F_MODE_HI    7
`define SP_F_SMOD       0

`define SP_MODE_SHIFT   2'h0
`define SP_MODE_8BIT    2'h1
`define SP_MODE_9FIX    2'h2

`define SP_STATE1_PHASE1         4'h0
`define SP_STATE3_PHASE1         4'h4
`define SP_STATE5_PHASE2         4'h9
`define SP_STATE6_PHASE1         4'ha
`define SP_STATE6_PHASE2         4'hb

`define SP_DIV_LAST     4'hf
`define SP_SAMP_FIRST   4'h7
`define SP_SAMP_LAST    4'h9
`define SP_M2_SLOW_LAST 2'h3

`define SP_TX_MARK      8'h01
`define SP_TX_DONE      9'h001
`define SP_RX_M0_LOAD   8'h7f
`define SP_RX_AS_LOAD   9'h1ff
`define SP_LINE_IDLE    1'b1

`endif

// ===== rtl/serial_port_pkg.sv
// Types shared by the four mode serial port
package serial_port_pkg;

	typedef enum logic [2:0] {
		TX_IDLE     = 3'h0,
		TX_M0_PEND  = 3'h1,
		TX_M0_ARM   = 3'h3,
		TX_M0_SEND  = 3'h2,
		TX_AS_REQ   = 3'h4,
		TX_AS_GO    = 3'h5,
		TX_AS_START = 3'h7,
		TX_AS_DATA  = 3'h6
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE     = 3'h0,
		RX_M0_ARM   = 3'h1,
		RX_M0_SHIFT = 3'h3,
		RX_AS_BITS  = 3'h4,
		RX_AS_GAP   = 3'h5
	} rx_state_t;

	typedef enum logic [1:0] {
		REG_NONE = 2'h0,
		REG_CTRL = 2'h1,
		REG_BUF  = 2'h2,
		REG_BAUD = 2'h3
	} reg_sel_t;

	typedef struct packed {
		logic       ack;
		logic [7:0] rdat;
		logic [1:0] mode;
		logic       sm2;
		logic       ren;
		logic       tb8;
		logic       rb8;
		logic       ti;
		logic       ri;
		logic       smod;
		logic [7:0] serial_buffer_reg;
		logic [3:0] mc;
		logic [1:0] pre;
		tx_state_t  tx_st;
		logic [8:0] tsr;
		logic       tx_first;
		logic [3:0] tx_div;
		rx_state_t  rx_st;
		logic [8:0] rsr;
		logic       m0_wait;
		logic [3:0] rx_div;
		logic [2:0] maj;
		logic       samp;
		logic [2:0] sy;
		logic       rx_f;
		logic       rx_prev;
		logic       txd;
		logic       rxo;
		logic       rxoe;
	} port_state_t;

endpackage
